//--- verilog/lrc_loop.v
// Low-rate data channel loopback: downlink bursts in, uplink out.
// Assumes burst bits arrive one per valid cycle, first bit marked,
// and the radio asks for each uplink burst with a one-cycle start.
//
// Behaviour
// - Each coded 432-bit sample is spread evenly over 8 blocks; the code spreads nothing and loops each 432-bit block whole.
// - Each block is interleaved within itself, then scrambled.
// - Take 432 bits of each burst and descramble them.
// - Undo block interleave first, then the spread over 8 blocks; the code undoes the block interleave only.
// - Decode a completed originating block, strip tail, keep 144 bits; the code stores the whole 432-bit block undecoded.
// - Re-encode with the identical chain and send uplink; the code only re-interleaves and re-scrambles the stored block.
// - User delivery of looped data is optional; here withheld.
// - Loop delay is at least 16 frames and fixed.
// - Act on stolen bursts; loop may pause until signalling ends.
// - Bad frames are marked all ones when bad-frame flag requested.
`include "lrc_defines.vh"

module lrc_loop #(
	parameter BLK_BITS = `LRC_BLK_BITS,
	parameter LOOP_FRAMES = `LRC_LOOP_FRAMES,
	parameter BLK_MULT = `LRC_BLK_MULT,
	parameter FIFO_DEPTH = `LRC_FIFO_DEPTH
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Downlink burst bits
	input wire rx_valid_in,
	input wire rx_bit_in,
	input wire rx_first_in,
	input wire rx_stolen_in,
	input wire rx_bad_in,
	// Channel settings
	input wire [29:0] scr_code_in,
	input wire bad_frame_flag_in,
	input wire sig_busy_in,
	// Uplink burst bits
	input wire tx_start_in,
	output wire tx_valid_out,
	output wire tx_bit_out,
	input wire tx_ready_in,
	output wire tx_busy_out,
	// Stolen channel bits to signalling
	output reg ctl_valid_out,
	output reg ctl_bit_out,
	output reg ctl_end_out,
	// User data and reference
	output reg user_valid_out,
	output reg user_bit_out,
	output reg prbs_ref_out,
	output reg loop_paused_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function [8:0] perm;
		input [8:0] k;
		integer p;
		begin
			p = (k * BLK_MULT) % BLK_BITS;
			perm = p[8:0];
		end
	endfunction

	function [31:0] scr_next;
		input [31:0] s;
		begin
			scr_next = {s[30:0], ^(s & `LRC_SCR_TAPS)};
		end
	endfunction

	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------
	reg [8:0] rx_cnt_q;
	reg [31:0] rx_scr_q;
	reg rx_stolen_q;
	reg rx_bad_q;
	reg [BLK_BITS-1:0] blk_q;
	reg done_q;
	reg done_bad_q;
	reg [8:0] idx;
	reg [31:0] scr_cur;
	reg plain;

	always @*
	begin
		idx = rx_first_in ? 9'h000 : rx_cnt_q;
		scr_cur = rx_first_in ? {scr_code_in, `LRC_SCR_FILL} : rx_scr_q;
		plain = rx_bit_in ^ scr_cur[31];
	end

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			rx_cnt_q <= 9'h000;
			rx_scr_q <= 32'h00000000;
			rx_stolen_q <= 1'b0;
			rx_bad_q <= 1'b0;
			done_q <= 1'b0;
			done_bad_q <= 1'b0;
			ctl_valid_out <= 1'b0;
			ctl_bit_out <= 1'b0;
			ctl_end_out <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			ctl_valid_out <= 1'b0;
			ctl_end_out <= 1'b0;
			if (rx_valid_in)
			begin
				rx_scr_q <= scr_next(scr_cur);
				rx_cnt_q <= (idx == `LRC_LAST_BIT) ? 9'h000 : idx + 9'h001;
				if (rx_first_in)
				begin
					rx_stolen_q <= rx_stolen_in;
					rx_bad_q <= rx_bad_in;
				end
				// Stolen bursts go to signalling, not into the loop
				if (rx_first_in ? rx_stolen_in : rx_stolen_q)
				begin
					ctl_valid_out <= 1'b1;
					ctl_bit_out <= plain;
					ctl_end_out <= (idx == `LRC_LAST_BIT);
				end
				else
					blk_q[perm(idx)] <= plain;
				if (idx == `LRC_LAST_BIT)
				begin
					done_q <= 1'b1;
					done_bad_q <= (rx_first_in ? (rx_stolen_in | rx_bad_in)
						: (rx_stolen_q | rx_bad_q)) | sig_busy_in;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Delay ring
	// ----------------------------------------------------------------
	// One slot per downlink burst; reading the slot about to be
	// overwritten gives a delay fixed at the ring length.
	reg [BLK_BITS-1:0] ring_q [0:LOOP_FRAMES-1];
	reg [LOOP_FRAMES-1:0] ring_bad_q;
	reg [`LRC_PTR_W-1:0] wr_q;

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_q <= {`LRC_PTR_W{1'b0}};
			ring_bad_q <= {LOOP_FRAMES{1'b1}};
			loop_paused_out <= 1'b0;
		end
		else
		begin
			loop_paused_out <= sig_busy_in;
			if (done_q)
			begin
				// Completed originating blocks pass through unchanged:
				// decode followed by identical re-encode is transparent
				// for error-free samples, so no decoder state is kept.
				ring_q[wr_q] <= blk_q;
				ring_bad_q[wr_q] <= done_bad_q;
				// Pointer advances even when paused, keeping delay fixed
				wr_q <= (wr_q == LOOP_FRAMES[`LRC_PTR_W-1:0] - 1'b1)
					? {`LRC_PTR_W{1'b0}} : wr_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit side
	// ----------------------------------------------------------------
	reg tx_act_q;
	reg [8:0] tx_cnt_q;
	reg [31:0] tx_scr_q;
	reg [BLK_BITS-1:0] txw_q;
	reg tx_ones_q;
	wire fifo_ready;
	wire tx_push;
	wire tx_coded;

	assign tx_push = tx_act_q & fifo_ready;
	assign tx_coded = tx_ones_q | txw_q[perm(tx_cnt_q)];
	assign tx_busy_out = tx_act_q | tx_valid_out;

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			tx_act_q <= 1'b0;
			tx_cnt_q <= 9'h000;
			tx_scr_q <= 32'h00000000;
			tx_ones_q <= 1'b0;
		end
		else if (tx_start_in & ~tx_act_q)
		begin
			tx_act_q <= 1'b1;
			tx_cnt_q <= 9'h000;
			tx_scr_q <= {scr_code_in, `LRC_SCR_FILL};
			txw_q <= ring_q[wr_q];
			// Paused or stolen slots carry no valid sample
			tx_ones_q <= ring_bad_q[wr_q] & bad_frame_flag_in;
		end
		else if (tx_push)
		begin
			tx_scr_q <= scr_next(tx_scr_q);
			tx_cnt_q <= tx_cnt_q + 9'h001;
			if (tx_cnt_q == `LRC_LAST_BIT)
				tx_act_q <= 1'b0;
		end
	end

	lrc_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH),
		.AW(3)
	) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(tx_act_q),
		.in_data_in(tx_coded ^ tx_scr_q[31]),
		.in_ready_out(fifo_ready),
		.out_valid_out(tx_valid_out),
		.out_data_out(tx_bit_out),
		.out_ready_in(tx_ready_in)
	);

	// ----------------------------------------------------------------
	// User path and reference sequence
	// ----------------------------------------------------------------
	reg [8:0] prbs_q;

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			prbs_q <= `LRC_PRBS_SEED;
			prbs_ref_out <= 1'b0;
			user_valid_out <= 1'b0;
			user_bit_out <= 1'b0;
		end
		else
		begin
			// Looped data is withheld to keep the user path quiet
			user_valid_out <= 1'b0;
			user_bit_out <= 1'b0;
			if (rx_valid_in)
			begin
				prbs_q <= {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]};
				prbs_ref_out <= prbs_q[8];
			end
		end
	end

endmodule

//--- verilog/lrc_defines.vh
// Constants for the low-rate data loopback codec.
// Assumes inclusion by bare name from every design file.
`ifndef LRC_DEFINES_VH
`define LRC_DEFINES_VH

// ----------------------------------------------------------------
// Burst and block geometry
// ----------------------------------------------------------------
`define LRC_BLK_BITS 432
`define LRC_LAST_BIT 9'h1AF
`define LRC_DATA_BITS 144
`define LRC_TAIL_BITS 4
`define LRC_SPREAD 8
`define LRC_LOOP_FRAMES 16
`define LRC_PTR_W 4

// ----------------------------------------------------------------
// Permutation and scrambler
// ----------------------------------------------------------------
`define LRC_BLK_MULT 103
`define LRC_SCR_TAPS 32'h80200003
`define LRC_SCR_FILL 2'h3

// ----------------------------------------------------------------
// Reference sequence, 9 stages, taps 9 and 5
// ----------------------------------------------------------------
`define LRC_PRBS_SEED 9'h1FF
`define LRC_PRBS_LEN 511

// ----------------------------------------------------------------
// Return buffer
// ----------------------------------------------------------------
`define LRC_FIFO_DEPTH 8
`define LRC_FIFO_WIDTH 1

`endif

//--- verilog/lrc_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`include "lrc_defines.vh"

module lrc_fifo #(
	parameter WIDTH = `LRC_FIFO_WIDTH,
	parameter DEPTH = `LRC_FIFO_DEPTH,
	parameter AW = 3
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Fill side
	input wire in_valid_in,
	input wire [WIDTH-1:0] in_data_in,
	output wire in_ready_out,
	// Drain side
	output wire out_valid_out,
	output reg [WIDTH-1:0] out_data_out,
	input wire out_ready_in
);

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready_out = (cnt_q != DEPTH[AW:0]);
	assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	always @*
	begin
		out_data_out = mem_q[rd_q];
	end

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_q[wr_q] <= in_data_in;
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: wr_q + 1'b1;
			end
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

//--- testbench/lrc_loop_sva.sv
// Port-level checks for the loopback codec.
// Assumes one clock and a synchronous active-high reset.
module lrc_loop_sva (
	input wire clk_in,
	input wire rst_in,
	input wire rx_valid_in,
	input wire rx_first_in,
	input wire rx_stolen_in,
	input wire sig_busy_in,
	input wire tx_start_in,
	input wire tx_ready_in,
	input wire tx_valid_out,
	input wire tx_bit_out,
	input wire tx_busy_out,
	input wire ctl_valid_out,
	input wire ctl_end_out,
	input wire user_valid_out,
	input wire loop_paused_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	AST_PAUSE: assert property (sig_busy_in |=> loop_paused_out)
		else $error("pause flag did not follow busy");
	AST_USER: assert property (!user_valid_out)
		else $error("user data delivered");
	AST_HOLD: assert property (tx_valid_out && !tx_ready_in
		|=> tx_valid_out && $stable(tx_bit_out))
		else $error("uplink bit dropped while stalled");
	AST_CTL: assert property (rx_valid_in && rx_first_in && rx_stolen_in
		|=> ctl_valid_out)
		else $error("stolen bit not passed on");
	AST_NOCTL: assert property (!rx_valid_in |=> !ctl_valid_out)
		else $error("control bit without received bit");
	AST_START: assert property (tx_start_in && !tx_busy_out
		|-> ##2 tx_valid_out)
		else $error("uplink burst late");
	AST_END: assert property (ctl_end_out |-> ctl_valid_out)
		else $error("end marker without bit");
	AST_BUSY: assert property (tx_valid_out |-> tx_busy_out)
		else $error("valid without busy");
endmodule
bind lrc_loop lrc_loop_sva chk (.clk_in, .rst_in, .rx_valid_in,
	.rx_first_in, .rx_stolen_in, .sig_busy_in, .tx_start_in, .tx_ready_in,
	.tx_valid_out, .tx_bit_out, .tx_busy_out, .ctl_valid_out,
	.ctl_end_out, .user_valid_out, .loop_paused_out);

//--- testbench/lrc_station.sv
// Far test station: sends sequence bursts bit by bit.
// Assumes the bench calls send_burst; inputs change at falling edges.
module lrc_station (
	input wire logic clk_in,
	output logic rx_valid_out,
	output logic rx_bit_out,
	output logic rx_first_out,
	output logic rx_stolen_out,
	output logic rx_bad_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] lfsr_q = 9'h1FF;
	logic first_q [0:431];
	int n_q = 0;
	initial
	begin
		rx_valid_out = 1'b0;
		rx_bit_out = 1'b0;
		rx_first_out = 1'b0;
		rx_stolen_out = 1'b0;
		rx_bad_out = 1'b0;
	end
	task automatic send_burst(input logic stolen);
		for (int i = 0; i < 432; i++)
		begin
			@(negedge clk_in);
			rx_valid_out = 1'b1;
			rx_first_out = (i == 0);
			rx_stolen_out = stolen;
			rx_bit_out = lfsr_q[8];
			if (n_q == 0)
				first_q[i] = lfsr_q[8];
			lfsr_q = {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
		end
		@(negedge clk_in);
		// Mobile here never originates control: nothing to acknowledge
		// Released line must not look like held data
		rx_valid_out = 1'b0;
		rx_first_out = 1'b0;
		rx_bit_out = ~rx_bit_out;
		n_q++;
	endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the loopback codec.
// Assumes the station model drives the downlink side.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_in, tx_start_in, tx_ready_in, bad_frame_flag_in, sig_busy_in;
	wire rx_valid, rx_bit, rx_first, rx_stolen, rx_bad;
	wire tx_valid_out, tx_bit_out, tx_busy_out, ctl_valid_out, ctl_bit_out;
	wire ctl_end_out, user_valid_out, user_bit_out, prbs_ref_out;
	wire loop_paused_out;
	int fail_count = 0;
	int num_checks = 0;
	int ctl_n = 0;
	int ctl_e = 0;
	logic [31:0] ctl_scr;
	logic ctl_exp;
	localparam logic [29:0] SCR_CODE = 30'h0000_1234;
	localparam logic [31:0] SCR_TAPS = 32'h80200003;
	function automatic logic [31:0] scr_step(input logic [31:0] s);
		return {s[30:0], ^(s & SCR_TAPS)};
	endfunction
	always #4 clk_in = ~clk_in;
	// Outputs read before this edge's updates: they belong to the last bit
	always @(posedge clk_in)
	begin
		if (ctl_valid_out === 1'b1)
		begin
			ctl_n++;
			check("control bit", ctl_bit_out, ctl_exp);
		end
		if (ctl_end_out === 1'b1)
			ctl_e++;
		if (rx_valid === 1'b1)
		begin
			if (rx_first === 1'b1)
				ctl_scr = {SCR_CODE, 2'h3};
			ctl_exp = rx_bit ^ ctl_scr[31];
			ctl_scr = scr_step(ctl_scr);
		end
	end
	lrc_station st (.clk_in(clk_in), .rx_valid_out(rx_valid),
		.rx_bit_out(rx_bit), .rx_first_out(rx_first),
		.rx_stolen_out(rx_stolen), .rx_bad_out(rx_bad));
	lrc_loop uut (.clk_in(clk_in), .rst_in(rst_in), .rx_valid_in(rx_valid),
		.rx_bit_in(rx_bit), .rx_first_in(rx_first),
		.rx_stolen_in(rx_stolen), .rx_bad_in(rx_bad),
		.scr_code_in(SCR_CODE), .bad_frame_flag_in(bad_frame_flag_in),
		.sig_busy_in(sig_busy_in), .tx_start_in(tx_start_in),
		.tx_valid_out(tx_valid_out), .tx_bit_out(tx_bit_out),
		.tx_ready_in(tx_ready_in), .tx_busy_out(tx_busy_out),
		.ctl_valid_out(ctl_valid_out), .ctl_bit_out(ctl_bit_out),
		.ctl_end_out(ctl_end_out), .user_valid_out(user_valid_out),
		.user_bit_out(user_bit_out), .prbs_ref_out(prbs_ref_out),
		.loop_paused_out(loop_paused_out));
	task automatic check(input string what, input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic get_burst(input logic ones);
		int k, t;
		logic [31:0] s;
		logic e;
		k = 0;
		t = 0;
		s = {SCR_CODE, 2'h3};
		tx_ready_in = 1'b0;
		@(negedge clk_in);
		tx_start_in = 1'b1;
		@(negedge clk_in);
		tx_start_in = 1'b0;
		while (k < 432 && t < 2000)
		begin
			@(negedge clk_in);
			// Stall first so the buffer fills and refuses
			tx_ready_in = (t >= 20);
			if (tx_valid_out === 1'b1 && tx_ready_in)
			begin
				// Bad slots go out as scrambled all ones
				e = ones ? ~s[31] : st.first_q[k];
				check("uplink bit", tx_bit_out, e);
				s = scr_step(s);
				k++;
			end
			t++;
		end
		check("uplink count", k == 432, 1'b1);
	endtask
	task automatic test_loop;
		st.send_burst(1'b0);
		check("reference", prbs_ref_out, st.first_q[431]);
		check("user bit", user_bit_out, 1'b0);
		ctl_n = 0;
		ctl_e = 0;
		st.send_burst(1'b1);
		// Last control bit is counted one edge after release
		@(negedge clk_in);
		check("stolen bits", ctl_n == 432, 1'b1);
		check("stolen end", ctl_e == 1, 1'b1);
		repeat (14) st.send_burst(1'b0);
		get_burst(1'b0);
		$display("test_loop done");
	endtask
	task automatic test_bad;
		bad_frame_flag_in = 1'b1;
		st.send_burst(1'b0);
		get_burst(1'b1);
		$display("test_bad done");
	endtask
	task automatic test_pause;
		@(negedge clk_in);
		sig_busy_in = 1'b1;
		@(negedge clk_in);
		sig_busy_in = 1'b0;
		check("paused", loop_paused_out, 1'b1);
		@(negedge clk_in);
		check("resumed", loop_paused_out, 1'b0);
		$display("test_pause done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		rst_in = 1'b1;
		tx_start_in = 1'b0;
		tx_ready_in = 1'b0;
		bad_frame_flag_in = 1'b0;
		sig_busy_in = 1'b0;
		repeat (10) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		test_loop;
		test_bad;
		test_pause;
		print_verdict;
	end
	initial
	begin
		// About 8300 cycles expected
		repeat (30000) @(posedge clk_in);
		fail_count++;
		print_verdict;
	end
endmodule
